// ### hw/flash_ctrl_map.vh
`ifndef FLASH_CTRL_MAP_VH
`define FLASH_CTRL_MAP_VH

// register offsets on the plain register port
`define OFS_DATA_BYTE 3'h0
`define OFS_POINTER 3'h1
`define OFS_CONTROL 3'h2
`define OFS_IRQ_STATUS 3'h3
`define OFS_IRQ_MASK 3'h4
`define OFS_PROTECT 3'h5

// control register bit positions
`define BIT_FREE 4
`define BIT_WRITE_ERROR_FLAG 3
`define BIT_WRITE_ENABLE_BIT 2
`define BIT_WR 1
`define BIT_RD 0

// interrupt status / mask bit positions
`define IRQ_DONE 0
`define IRQ_ERR 1
`define IRQ_ABORT 2

// pointer fields
`define PTR_MSB 5
`define ROW_MSB 5
`define ROW_LSB 3
`define LAST_LATCH 2'h3

// reset and erased values
`define RST_BYTE 8'h00
`define ERASED_BYTE 8'hFF

// timing
`define CLK_FREQ_MHZ 125
`define ERASE_TIME_NS 2000
`define WRITE_TIME_NS 2000
`define LATCH_CYCLES 1
`define ERASE_CYCLES ((`ERASE_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define WRITE_CYCLES ((`WRITE_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)

`endif

// ### hw/flash_data_array.v
`timescale 1ns/1ps
`include "flash_ctrl_map.vh"

module flash_data_array #(
  parameter DEPTH = 64,
  parameter AW = 6
) (
  // clock and power-on reset
  input wire clk_in,
  input wire pwr_rst_in,
  // read side
  input wire [AW-1:0] rd_addr_in,
  output wire [7:0] rd_data_out,
  // write latch load
  input wire latch_we_in,
  input wire [1:0] latch_idx_in,
  input wire [7:0] latch_data_in,
  // row erase and four-byte program commits
  input wire erase_go_in,
  input wire [2:0] erase_row_in,
  input wire prog_go_in,
  input wire [AW-3:0] prog_word_in
);

  reg [7:0] mem_q [0:DEPTH-1];
  reg [7:0] latch_q [0:3];
  integer i;

  assign rd_data_out = mem_q[rd_addr_in];

  // storage survives device reset; only power-on clears it to erased
  always @(posedge clk_in or posedge pwr_rst_in)
  begin
    if (pwr_rst_in)
    begin
      for (i = 0; i < DEPTH; i = i + 1)
        mem_q[i] <= `ERASED_BYTE;
      for (i = 0; i < 4; i = i + 1)
        latch_q[i] <= `ERASED_BYTE;
    end
    else
    begin
      if (latch_we_in)
        latch_q[latch_idx_in] <= latch_data_in;
      if (erase_go_in)
      begin
        for (i = 0; i < 8; i = i + 1)
          mem_q[{erase_row_in, i[2:0]}] <= `ERASED_BYTE;
      end
      else if (prog_go_in)
      begin
        for (i = 0; i < 4; i = i + 1)
          mem_q[{prog_word_in, i[1:0]}] <= latch_q[i];
      end
    end
  end

endmodule

// ### hw/flash_data_mem_access_ctrl.v
`timescale 1ns/1ps
`include "flash_ctrl_map.vh"

module flash_data_mem_access_ctrl #(
  parameter ERASE_CYCLES = `ERASE_CYCLES,
  parameter WRITE_CYCLES = `WRITE_CYCLES,
  parameter CW = 12
) (
  // clock and resets
  input wire MCLK_IN,
  input wire SYS_RST_IN,
  input wire PWR_ON_RST_IN,
  // register port
  input wire [2:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  output reg [7:0] REG_RDATA_OUT,
  // code protection state
  input wire CODE_PROTECT_IN,
  // interrupt
  output reg IRQ_OUT
);

  localparam [CW-1:0] ERASE_CNT = ERASE_CYCLES[CW-1:0];
  localparam [CW-1:0] WRITE_CNT = WRITE_CYCLES[CW-1:0];
  localparam integer LATCH_CYCLES_I = `LATCH_CYCLES;
  localparam [CW-1:0] LATCH_CNT = LATCH_CYCLES_I[CW-1:0];
  localparam [CW-1:0] CNT_ONE = {{(CW-1){1'b0}}, 1'b1};

  reg [7:0] data_q;
  reg [5:0] ptr_q;
  reg free_q, write_error_flag_q, write_enable_bit_q, wr_q;
  reg free_new_q, write_enable_new_q;
  reg erase_op_q, prog_op_q;
  reg [CW-1:0] cnt_q;
  reg first_q;
  reg cycle_mark_q;
  reg [2:0] irq_stat_q, irq_mask_q;
  reg [2:0] irq_stat_d;
  reg [7:0] rdata_d;

  wire [7:0] wd = REG_WDATA_IN;
  wire data_wr = REG_WR_IN && (REG_ADDR_IN == `OFS_DATA_BYTE);
  wire ptr_wr = REG_WR_IN && (REG_ADDR_IN == `OFS_POINTER);
  wire ctrl_wr = REG_WR_IN && (REG_ADDR_IN == `OFS_CONTROL);
  wire stat_wr = REG_WR_IN && (REG_ADDR_IN == `OFS_IRQ_STATUS);
  wire mask_wr = REG_WR_IN && (REG_ADDR_IN == `OFS_IRQ_MASK);
  // protection is deliberately not part of any gate here
  wire start = ctrl_wr && wd[`BIT_WR] && write_enable_bit_q && !wr_q;
  wire read_go = ctrl_wr && wd[`BIT_RD] && !wr_q;
  wire done = wr_q && (cnt_q == CNT_ONE);
  wire free_drop = free_new_q && !(ctrl_wr && wd[`BIT_WRITE_ENABLE_BIT]);
  wire write_enable_drop = write_enable_new_q && !(ctrl_wr && wd[`BIT_WR]);
  wire last_latch = (ptr_q[1:0] == `LAST_LATCH);
  wire [7:0] array_byte;

  flash_data_array #(
    .DEPTH(64),
    .AW(6)
  ) flash_data_array_i (
    .clk_in(MCLK_IN),
    .pwr_rst_in(PWR_ON_RST_IN),
    .rd_addr_in(ptr_q),
    .rd_data_out(array_byte),
    .latch_we_in(start && !free_q),
    .latch_idx_in(ptr_q[1:0]),
    .latch_data_in(data_q),
    .erase_go_in(done && erase_op_q),
    .erase_row_in(ptr_q[`ROW_MSB:`ROW_LSB]),
    .prog_go_in(done && prog_op_q),
    .prog_word_in(ptr_q[5:2])
  );

  // data and pointer; writes during a running cycle are dropped, as the core would stall
  always @(posedge MCLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      data_q <= `RST_BYTE;
      ptr_q <= 6'h00;
    end
    else
    begin
      if (read_go)
        data_q <= array_byte;
      else if (data_wr && !wr_q)
        data_q <= wd;
      if (ptr_wr && !wr_q)
        ptr_q <= wd[`PTR_MSB:0];
    end
  end

  // control bits, unlock windows and cycle timer
  always @(posedge MCLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      free_q <= 1'b0;
      write_error_flag_q <= 1'b0;
      write_enable_bit_q <= 1'b0;
      wr_q <= 1'b0;
      free_new_q <= 1'b0;
      write_enable_new_q <= 1'b0;
      erase_op_q <= 1'b0;
      prog_op_q <= 1'b0;
      cnt_q <= {CW{1'b0}};
      first_q <= 1'b1;
    end
    else
    begin
      first_q <= 1'b0;
      free_new_q <= ctrl_wr && !wr_q && wd[`BIT_FREE] && !free_q;
      write_enable_new_q <= ctrl_wr && !wr_q && wd[`BIT_WRITE_ENABLE_BIT] && !write_enable_bit_q;
      if (wr_q)
      begin
        cnt_q <= cnt_q - CNT_ONE;
        if (done)
        begin
          wr_q <= 1'b0;
          write_enable_bit_q <= 1'b0;
          write_error_flag_q <= 1'b0;
          erase_op_q <= 1'b0;
          prog_op_q <= 1'b0;
          if (erase_op_q)
            free_q <= 1'b0;
        end
      end
      else if (start)
      begin
        wr_q <= 1'b1;
        erase_op_q <= free_q;
        prog_op_q <= !free_q && last_latch;
        if (free_q)
          cnt_q <= ERASE_CNT;
        else if (last_latch)
          cnt_q <= WRITE_CNT;
        else
          cnt_q <= LATCH_CNT;
      end
      else
      begin
        if (free_drop)
          free_q <= 1'b0;
        else if (ctrl_wr)
          free_q <= wd[`BIT_FREE];
        if (write_enable_drop)
          write_enable_bit_q <= 1'b0;
        else if (ctrl_wr)
          write_enable_bit_q <= wd[`BIT_WRITE_ENABLE_BIT];
        if (first_q && cycle_mark_q)
          write_error_flag_q <= 1'b1;
        else if (ctrl_wr)
          write_error_flag_q <= wd[`BIT_WRITE_ERROR_FLAG];
      end
    end
  end

  // marks a running cycle across device reset; only power-on clears it outright
  always @(posedge MCLK_IN or posedge PWR_ON_RST_IN)
  begin
    if (PWR_ON_RST_IN)
      cycle_mark_q <= 1'b0;
    else if (start)
      cycle_mark_q <= 1'b1;
    else if (done || (first_q && !SYS_RST_IN))
      cycle_mark_q <= 1'b0;
  end

  // sticky events: a new event beats a clear in the same cycle
  always @*
  begin
    irq_stat_d = irq_stat_q;
    if (stat_wr)
      irq_stat_d = irq_stat_d & ~wd[2:0];
    if (done)
      irq_stat_d[`IRQ_DONE] = 1'b1;
    if (first_q && cycle_mark_q)
      irq_stat_d[`IRQ_ERR] = 1'b1;
    if ((free_drop || write_enable_drop) && !start)
      irq_stat_d[`IRQ_ABORT] = 1'b1;
  end

  // read mux, answered the cycle after the strobe
  always @*
  begin
    rdata_d = 8'h00;
    if (REG_ADDR_IN == `OFS_DATA_BYTE)
      rdata_d = data_q;
    else if (REG_ADDR_IN == `OFS_POINTER)
      rdata_d = {2'b00, ptr_q};
    else if (REG_ADDR_IN == `OFS_CONTROL)
      rdata_d = {3'b000, free_q, write_error_flag_q, write_enable_bit_q, wr_q, 1'b0};
    else if (REG_ADDR_IN == `OFS_IRQ_STATUS)
      rdata_d = {5'b00000, irq_stat_q};
    else if (REG_ADDR_IN == `OFS_IRQ_MASK)
      rdata_d = {5'b00000, irq_mask_q};
    else if (REG_ADDR_IN == `OFS_PROTECT)
      rdata_d = {7'h00, CODE_PROTECT_IN};
  end

  // interrupt registers and registered outputs
  always @(posedge MCLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      irq_stat_q <= 3'h0;
      irq_mask_q <= 3'h0;
      IRQ_OUT <= 1'b0;
      REG_RDATA_OUT <= 8'h00;
    end
    else
    begin
      irq_stat_q <= irq_stat_d;
      if (mask_wr)
        irq_mask_q <= wd[2:0];
      IRQ_OUT <= |(irq_stat_d & (mask_wr ? wd[2:0] : irq_mask_q));
      REG_RDATA_OUT <= REG_RD_IN ? rdata_d : 8'h00;
    end
  end

endmodule

// ### tb/flash_data_mem_access_ctrl_props.sv
`timescale 1ns/1ps
module flash_ctrl_props #(
  parameter ERASE_CYCLES = 250,
  parameter WRITE_CYCLES = 250,
  parameter CW = 12
) (
  // clock and resets
  input wire MCLK_IN,
  input wire SYS_RST_IN,
  input wire PWR_ON_RST_IN,
  // register port
  input wire [2:0] REG_ADDR_IN,
  input wire [7:0] REG_WDATA_IN,
  input wire REG_WR_IN,
  input wire REG_RD_IN,
  input wire [7:0] REG_RDATA_OUT,
  // side signals
  input wire CODE_PROTECT_IN,
  input wire IRQ_OUT
);
  default clocking @(posedge MCLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // one strobe bit per offset keeps the properties short
  wire [7:0] wa = {7'h00, REG_WR_IN} << REG_ADDR_IN;
  wire [7:0] ra = {7'h00, REG_RD_IN} << REG_ADDR_IN;
  wire [7:0] wd = REG_WDATA_IN;
  wire [7:0] q = REG_RDATA_OUT;
  property p_data;
    wa[0] ##1 ra[0] |=> q == $past(wd, 2);
  endproperty
  a_data: assert property (p_data) else $error("data byte lost");
  property p_ptr;
    wa[1] ##1 ra[1] |=> q == ($past(wd, 2) & 8'h3F);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer readback wrong");
  property p_ptr_hi;
    ra[1] |=> q[7:6] == 2'h0;
  endproperty
  a_ptr_hi: assert property (p_ptr_hi) else $error("pointer top bits set");
  property p_en_drop;
    wa[2] && wd == 8'h04 ##1 !wa[2] ##1 ra[2] |=> !q[2];
  endproperty
  a_en_drop: assert property (p_en_drop) else $error("enable kept");
  property p_sel_drop;
    wa[2] && wd == 8'h10 ##1 !wa[2] ##1 ra[2] |=> !q[4];
  endproperty
  a_sel_drop: assert property (p_sel_drop) else $error("erase select kept");
  // busy shows on the read right after the start write
  property p_erase;
    wa[2] && wd == 8'h10 ##1 wa[2] && wd == 8'h14 ##1 wa[2] && wd == 8'h16
      ##1 ra[2] |=> q[4] && q[1];
  endproperty
  a_erase: assert property (p_erase) else $error("erase not running");
  property p_done;
    ra[2] ##1 q[1] ##1 ra[2] ##1 !q[1] |-> !q[3];
  endproperty
  a_done: assert property (p_done) else $error("error flag after finish");
  property p_prot;
    ra[5] |=> q == {7'h00, $past(CODE_PROTECT_IN)};
  endproperty
  a_prot: assert property (p_prot) else $error("protect readback wrong");
endmodule
bind flash_data_mem_access_ctrl flash_ctrl_props #(
  .ERASE_CYCLES(ERASE_CYCLES), .WRITE_CYCLES(WRITE_CYCLES), .CW(CW)
) props_i (
  .MCLK_IN(MCLK_IN), .SYS_RST_IN(SYS_RST_IN), .PWR_ON_RST_IN(PWR_ON_RST_IN),
  .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN), .REG_WR_IN(REG_WR_IN),
  .REG_RD_IN(REG_RD_IN), .REG_RDATA_OUT(REG_RDATA_OUT),
  .CODE_PROTECT_IN(CODE_PROTECT_IN), .IRQ_OUT(IRQ_OUT));

// ### tb/flash_data_mem_access_ctrl_tb_top.sv
`timescale 1ns/1ps
module flash_data_mem_access_ctrl_tb_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg por = 1'b1;
  reg [2:0] adr = 3'h0;
  reg [7:0] wd = 8'h00;
  reg we = 1'b0;
  reg re = 1'b0;
  reg prot = 1'b0;
  reg [7:0] v = 8'h00;
  wire [7:0] rdat;
  wire irq;
  integer error_cnt = 0;
  integer n_checks = 0;
  integer i;
  // short cycle counts keep the run brief
  flash_data_mem_access_ctrl #(.ERASE_CYCLES(4), .WRITE_CYCLES(4))
    flash_data_mem_access_ctrl_i (
    .MCLK_IN(clk), .SYS_RST_IN(rst), .PWR_ON_RST_IN(por), .REG_ADDR_IN(adr),
    .REG_WDATA_IN(wd), .REG_WR_IN(we), .REG_RD_IN(re), .REG_RDATA_OUT(rdat),
    .CODE_PROTECT_IN(prot), .IRQ_OUT(irq));
  initial forever #4 clk = ~clk;
  task close_out;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task ck(input [7:0] g, input [7:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // strobe stays up; the next call decides whether it drops
  task wr(input [2:0] a, input [7:0] d);
    begin
      @(posedge clk);
      adr <= a;
      wd <= d;
      we <= 1'b1;
      re <= 1'b0;
    end
  endtask
  task idle;
    begin
      @(posedge clk);
      we <= 1'b0;
      re <= 1'b0;
    end
  endtask
  // data stands one cycle only, so sample just after the taking edge
  task rd(input [2:0] a);
    begin
      @(posedge clk);
      adr <= a;
      we <= 1'b0;
      re <= 1'b1;
      @(posedge clk);
      re <= 1'b0;
      #1;
      v = rdat;
    end
  endtask
  task rc(input [2:0] a, input [7:0] e);
    begin
      rd(a);
      ck(v, e);
    end
  endtask
  // poll busy with a bound; running out counts as a mismatch
  task wdone;
    integer k;
    begin
      k = 0;
      v = 8'h02;
      while (v[1] && k < 40)
      begin
        rd(3'h2);
        k = k + 1;
      end
      if (v[1])
      begin
        ck(v & 8'h02, 8'h00);
        close_out;
      end
    end
  endtask
  task fetch(input [7:0] a, input [7:0] e);
    begin
      wr(3'h1, a);
      wr(3'h2, 8'h01);
      rc(3'h0, e);
    end
  endtask
  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    por <= 1'b0;
    for (i = 0; i < 7; i = i + 1)
      rc(i[2:0], 8'h00);
    wr(3'h1, 8'hFF);
    rc(3'h1, 8'h3F);
    wr(3'h0, 8'hA5);
    rc(3'h0, 8'hA5);
    wr(3'h2, 8'h02);
    rc(3'h2, 8'h00);
    wr(3'h2, 8'h04);
    idle;
    rc(3'h2, 8'h00);
    wr(3'h2, 8'h10);
    idle;
    rc(3'h2, 8'h00);
    rc(3'h3, 8'h04);
    wr(3'h4, 8'h04);
    rc(3'h4, 8'h04);
    ck({7'h00, irq}, 8'h01);
    wr(3'h3, 8'h04);
    rc(3'h3, 8'h00);
    ck({7'h00, irq}, 8'h00);
    // two words, rows 0 and 1, four latch loads each
    for (i = 4; i < 12; i = i + 1)
    begin
      wr(3'h1, i[7:0]);
      wr(3'h0, 8'hA0 + i[7:0]);
      wr(3'h2, 8'h04);
      wr(3'h2, 8'h06);
      wdone;
    end
    rc(3'h3, 8'h01);
    fetch(8'h09, 8'hA9);
    @(posedge clk);
    prot <= 1'b1;
    rc(3'h5, 8'h01);
    wr(3'h1, 8'h0D);
    wr(3'h2, 8'h10);
    wr(3'h2, 8'h14);
    wr(3'h2, 8'h16);
    rc(3'h2, 8'h16);
    wdone;
    rc(3'h2, 8'h00);
    fetch(8'h07, 8'hA7);
    fetch(8'h08, 8'hFF);
    fetch(8'h0B, 8'hFF);
    // device reset cuts a running erase short
    wr(3'h2, 8'h10);
    wr(3'h2, 8'h14);
    wr(3'h2, 8'h16);
    idle;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rc(3'h2, 8'h08);
    rc(3'h3, 8'h02);
    // a normal finish must clear the flag left by the cut cycle
    wr(3'h2, 8'h0C);
    wr(3'h2, 8'h0E);
    wdone;
    rc(3'h2, 8'h00);
    rc(3'h3, 8'h03);
    wr(3'h4, 8'h02);
    rc(3'h4, 8'h02);
    ck({7'h00, irq}, 8'h01);
    close_out;
  end
endmodule
